// *** logic/pc_regfile_consts.vh ***
`ifndef PC_REGFILE_CONSTS_VH
`define PC_REGFILE_CONSTS_VH
`define RESET_VECTOR 32'h0000_8000
`define EXCEPTION_VECTOR 32'h0000_8080
`define IRQ_VECTOR_FIRST 32'h0000_8004
`define IRQ_VECTOR_STEP 32'h0000_0004
`define IRQ_NUM_FIRST 4'h1
`define IRQ_NUM_LAST 4'hF
`define INSN_BYTES 32'h0000_0002
`define STACK_FRAME_FLAGS 16'h0006
`define STACK_WORD 16'h0002
`define REG_FAR_BASE 4'h8
`define REG_PAGE_ALT 4'h9
`define REG_BASE_LAST 4'hD
`define REG_STATUS 4'hE
`define REG_STACK 4'hF
`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define APB_PC 12'h008
`define APB_SP 12'h00C
`define APB_PSW 12'h010
`define APB_REG_BASE 12'h040
`define APB_REG_LAST 12'h07C
`define CTRL_RUN 0
`define CTRL_STEP 1
`define OP_NEXT 4'h0
`define OP_FAR_ABS 4'h1
`define OP_PAIR 4'h2
`define OP_REL12 4'h3
`define OP_RELREG 4'h4
`define OP_COND12 4'h5
`define OP_COND8 4'h6
`define OP_RET 4'h7
`define OP_FLAG_RESTORING_RETURN 4'h8
`define OP_IRQ 4'h9
`define OP_EXCEPT 4'hA
`endif

// *** logic/gp_regs.v ***
`timescale 1ns/1ps
`include "pc_regfile_consts.vh"
module gp_regs #(
	parameter NUM_REGS = 16,
	parameter WIDTH = 16
) (
	input wire clk,
	input wire reset,
	input wire wr_en,
	input wire wr_byte,
	input wire [3:0] wr_sel,
	input wire [WIDTH-1:0] wr_data,
	input wire [3:0] rd_sel_a,
	input wire [3:0] rd_sel_b,
	input wire rd_byte,
	output wire [WIDTH-1:0] rd_a,
	output wire [WIDTH-1:0] rd_b,
	output wire [WIDTH-1:0] status_word,
	output wire [WIDTH-1:0] stack_ptr
);
	reg [WIDTH-1:0] regs [0:NUM_REGS-1];
	genvar i;
	generate
		for (i = 0; i < NUM_REGS; i = i + 1) begin : g_reg
			always @(posedge clk) begin
				if (reset) begin
					regs[i] <= {WIDTH{1'b0}};
				end else if (wr_en && wr_sel == i) begin
					if (wr_byte) begin
						regs[i] <= {{(WIDTH-8){1'b0}}, wr_data[7:0]};
					end else begin
						regs[i] <= wr_data;
					end
				end
			end
		end
	endgenerate
	// Byte mode only looks at the low byte
	assign rd_a = rd_byte ? {{(WIDTH-8){1'b0}}, regs[rd_sel_a][7:0]} : regs[rd_sel_a];
	assign rd_b = rd_byte ? {{(WIDTH-8){1'b0}}, regs[rd_sel_b][7:0]} : regs[rd_sel_b];
	assign status_word = regs[`REG_STATUS];
	assign stack_ptr = regs[`REG_STACK];
endmodule // gp_regs

// *** logic/pc_regfile.v ***
`timescale 1ns/1ps
`include "pc_regfile_consts.vh"
// Overview of operation
// - A 32-bit program counter addresses code from 0000_8000H upward.
// - Bit zero of the program counter is always zero.
// - Reset loads 0000_8000H; an accepted exception loads 0000_8080H.
// - Interrupts jump to fixed vectors four bytes apart, 8004H to 803CH.
// - Far jump/call loads 24-bit target; pair form uses base<<16 plus source.
// - Short relative branch/call: pc plus 2 plus signed 12-bit offset.
// - Register-relative branch/call: pc plus 2 plus signed source register.
// - Taken conditional branch adds byte count plus signed 12 or 8 bit offset.
// - Return and flag-restoring return reload the full pc from stack words.
// - Sixteen 16-bit registers; byte mode uses the low 8 bits.
// - Byte-mode writes clear the upper 8 bits.
// - Register fourteen is the CPU status word.
// - Register eight is the base for the one-word far move unless a pair op or bus register access steers the shared read port.
// - Registers eight to thirteen are bases for the two-word far move, with the same pair op and bus register access exception.
// - Pair calls and jumps take upper pc bits from register eight or nine.
// - Interrupt pushes pc low, pc high, status; sp plus six unless a core or bus register write takes the port that cycle.
module pc_regfile (
	input wire CORE_CLK_IN,
	input wire RESET_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire WDOG_RESET_IN,
	input wire [3:0] OP_IN,
	input wire OP_VALID_IN,
	input wire [3:0] IRQ_NUM_IN,
	input wire [23:0] ABS_TARGET_IN,
	input wire [11:0] OFFSET_IN,
	input wire [3:0] BASE_SEL_IN,
	input wire [3:0] SRC_SEL_IN,
	input wire [2:0] INSN_BYTES_IN,
	input wire [31:0] STACK_DATA_IN,
	input wire MOVE_TWO_WORD_IN,
	input wire [3:0] MOVE_BASE_SEL_IN,
	input wire REG_WR_IN,
	input wire REG_WR_BYTE_IN,
	input wire [3:0] REG_WR_SEL_IN,
	input wire [15:0] REG_WR_DATA_IN,
	output reg [31:0] PRDATA_OUT,
	output reg PREADY_OUT,
	output reg PSLVERR_OUT,
	output reg [31:0] FETCH_ADDR_OUT,
	output reg [15:0] MOVE_BASE_OUT,
	output reg [15:0] PUSH_LOW_OUT,
	output reg [15:0] PUSH_HIGH_OUT,
	output reg [15:0] PUSH_STATUS_OUT,
	output reg PUSH_VALID_OUT,
	output reg OP_ERROR_OUT
);
	reg [31:0] pc;
	reg [31:0] next_pc;
	reg [1:0] ctrl;
	reg op_error;
	reg [3:0] base_sel;
	reg sp_upd;
	reg [15:0] next_sp;
	wire [15:0] rd_a;
	wire [15:0] rd_b;
	wire [15:0] status_word;
	wire [15:0] stack_ptr;
	wire [15:0] move_base;
	wire apb_acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	wire apb_wr = apb_acc && PWRITE_IN;
	wire apb_reg = PADDR_IN >= `APB_REG_BASE && PADDR_IN <= `APB_REG_LAST && PADDR_IN[1:0] == 2'h0;
	wire [3:0] apb_idx = PADDR_IN[5:2];
	wire run = ctrl[`CTRL_RUN] || ctrl[`CTRL_STEP];
	wire do_op = OP_VALID_IN && run;
	wire [31:0] off12 = {{20{OFFSET_IN[11]}}, OFFSET_IN};
	wire [31:0] off8 = {{24{OFFSET_IN[7]}}, OFFSET_IN[7:0]};
	wire [31:0] src_ext = {{16{rd_b[15]}}, rd_b};
	wire [31:0] nb = {29'h0, INSN_BYTES_IN};
	wire pair_ok = BASE_SEL_IN == `REG_FAR_BASE || BASE_SEL_IN == `REG_PAGE_ALT;
	wire irq_ok = IRQ_NUM_IN >= `IRQ_NUM_FIRST && IRQ_NUM_IN <= `IRQ_NUM_LAST;
	wire move_ok = MOVE_TWO_WORD_IN ? (MOVE_BASE_SEL_IN >= `REG_FAR_BASE &&
		MOVE_BASE_SEL_IN <= `REG_BASE_LAST) : 1'b1;
	// Software register writes are taken over the bus; the core port wins on collisions
	wire core_wr = REG_WR_IN;
	wire bus_wr = apb_wr && apb_reg && !core_wr;
	// Stack pointer update shares the write port as lowest priority
	wire wr_en = core_wr || bus_wr || sp_upd;
	wire [3:0] wr_sel = core_wr ? REG_WR_SEL_IN : (bus_wr ? apb_idx : `REG_STACK);
	wire [15:0] wr_data = core_wr ? REG_WR_DATA_IN : (bus_wr ? PWDATA_IN[15:0] : next_sp);
	wire wr_byte = core_wr ? REG_WR_BYTE_IN : 1'b0;
	always @* begin
		base_sel = BASE_SEL_IN;
		// A pair op outranks a bus read; an idle bus address must not steer the move base
		if (OP_VALID_IN && OP_IN == `OP_PAIR) begin
			base_sel = pair_ok ? BASE_SEL_IN : `REG_FAR_BASE;
		end else if (PSEL_IN && apb_reg) begin
			base_sel = apb_idx;
		end else begin
			base_sel = (MOVE_TWO_WORD_IN && move_ok) ? MOVE_BASE_SEL_IN : `REG_FAR_BASE;
		end
	end
	gp_regs #(
		.NUM_REGS(16),
		.WIDTH(16)
	) u_regs (
		.clk(CORE_CLK_IN),
		.reset(RESET_IN),
		.wr_en(wr_en),
		.wr_byte(wr_byte),
		.wr_sel(wr_sel),
		.wr_data(wr_data),
		.rd_sel_a(base_sel),
		.rd_sel_b(SRC_SEL_IN),
		.rd_byte(1'b0),
		.rd_a(rd_a),
		.rd_b(rd_b),
		.status_word(status_word),
		.stack_ptr(stack_ptr)
	);
	assign move_base = rd_a;
	always @* begin
		next_pc = pc;
		op_error = 1'b0;
		sp_upd = 1'b0;
		next_sp = stack_ptr;
		if (do_op) begin
			case (OP_IN)
			`OP_NEXT: begin
				next_pc = pc + nb;
			end
			`OP_FAR_ABS: begin
				next_pc = {8'h00, ABS_TARGET_IN};
			end
			`OP_PAIR: begin
				next_pc = {rd_a, rd_b};
				op_error = !pair_ok;
			end
			`OP_REL12: begin
				next_pc = pc + `INSN_BYTES + off12;
			end
			`OP_RELREG: begin
				next_pc = pc + `INSN_BYTES + src_ext;
			end
			`OP_COND12: begin
				next_pc = pc + nb + off12;
			end
			`OP_COND8: begin
				next_pc = pc + nb + off8;
			end
			`OP_RET, `OP_FLAG_RESTORING_RETURN: begin
				next_pc = STACK_DATA_IN;
			end
			`OP_IRQ: begin
				if (irq_ok) begin
					next_pc = `IRQ_VECTOR_FIRST + {26'h0, IRQ_NUM_IN - 4'h1, 2'h0};
					next_sp = stack_ptr + `STACK_FRAME_FLAGS;
					sp_upd = 1'b1;
				end else begin
					op_error = 1'b1;
				end
			end
			`OP_EXCEPT: begin
				next_pc = `EXCEPTION_VECTOR;
			end
			default: begin
				op_error = 1'b1;
			end
			endcase
		end
		next_pc[0] = 1'b0;
	end
	always @(posedge CORE_CLK_IN) begin
		if (RESET_IN || WDOG_RESET_IN) begin
			pc <= `RESET_VECTOR;
			FETCH_ADDR_OUT <= `RESET_VECTOR;
			PUSH_VALID_OUT <= 1'b0;
			PUSH_LOW_OUT <= 16'h0000;
			PUSH_HIGH_OUT <= 16'h0000;
			PUSH_STATUS_OUT <= 16'h0000;
			OP_ERROR_OUT <= 1'b0;
			MOVE_BASE_OUT <= 16'h0000;
		end else begin
			pc <= next_pc;
			FETCH_ADDR_OUT <= next_pc;
			PUSH_VALID_OUT <= do_op && OP_IN == `OP_IRQ && irq_ok;
			PUSH_LOW_OUT <= pc[15:0];
			PUSH_HIGH_OUT <= pc[31:16];
			PUSH_STATUS_OUT <= status_word;
			OP_ERROR_OUT <= op_error;
			MOVE_BASE_OUT <= move_base;
		end
	end
	// Single-step bit clears itself after one accepted operation
	always @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			ctrl <= 2'h1;
		end else if (apb_wr && PADDR_IN == `APB_CTRL) begin
			ctrl <= PWDATA_IN[1:0];
		end else if (do_op && ctrl[`CTRL_STEP]) begin
			ctrl[`CTRL_STEP] <= 1'b0;
		end
	end
	// Zero-wait slave: pready rises in each access phase
	always @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= PSEL_IN && !PENABLE_IN;
			PSLVERR_OUT <= 1'b0;
			if (PSEL_IN && !PENABLE_IN) begin
				PRDATA_OUT <= 32'h0000_0000;
				case (PADDR_IN)
				`APB_CTRL: PRDATA_OUT <= {30'h0, ctrl};
				`APB_STATUS: PRDATA_OUT <= {31'h0, OP_ERROR_OUT};
				`APB_PC: PRDATA_OUT <= pc;
				`APB_SP: PRDATA_OUT <= {16'h0, stack_ptr};
				`APB_PSW: PRDATA_OUT <= {16'h0, status_word};
				default: begin
					if (apb_reg) begin
						PRDATA_OUT <= {16'h0, rd_a};
					end else begin
						PSLVERR_OUT <= 1'b1;
					end
				end
				endcase
			end
		end
	end
endmodule // pc_regfile

// *** testbench/pc_regfile_checker.sv ***
`timescale 1ns/1ps
module pc_regfile_checker (
	input wire CORE_CLK_IN,
	input wire RESET_IN,
	input wire WDOG_RESET_IN,
	input wire OP_VALID_IN,
	input wire [3:0] OP_IN,
	input wire [3:0] IRQ_NUM_IN,
	input wire [23:0] ABS_TARGET_IN,
	input wire [11:0] OFFSET_IN,
	input wire [2:0] INSN_BYTES_IN,
	input wire [31:0] STACK_DATA_IN,
	input wire [31:0] FETCH_ADDR_OUT,
	input wire [15:0] PUSH_LOW_OUT,
	input wire [15:0] PUSH_HIGH_OUT,
	input wire PUSH_VALID_OUT,
	input wire OP_ERROR_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RESET_IN);
	// Watchdog wins over an op in the same cycle
	wire go = OP_VALID_IN & ~WDOG_RESET_IN;
	wire [31:0] pc = FETCH_ADDR_OUT;
	wire [31:0] off12 = {{20{OFFSET_IN[11]}}, OFFSET_IN};
	wire [31:0] off8 = {{24{OFFSET_IN[7]}}, OFFSET_IN[7:0]};
	pc_even_a: assert property (pc[0] == 1'b0)
		else $error("odd pc");
	wdog_vector_a: assert property (WDOG_RESET_IN |=> pc == 32'h0000_8000)
		else $error("bad reset vector");
	except_vector_a: assert property (go && OP_IN == 4'hA |=> pc == 32'h0000_8080)
		else $error("bad exception vector");
	irq_vector_a: assert property (go && OP_IN == 4'h9 && IRQ_NUM_IN != 4'h0
		|=> pc == 32'h0000_8000 + {$past(IRQ_NUM_IN), 2'b00}) else $error("bad irq vector");
	irq_push_a: assert property (go && OP_IN == 4'h9 && IRQ_NUM_IN != 4'h0
		|=> PUSH_VALID_OUT && {PUSH_HIGH_OUT, PUSH_LOW_OUT} == $past(pc)) else $error("bad push");
	far_abs_a: assert property (go && OP_IN == 4'h1
		|=> pc == ({8'h00, $past(ABS_TARGET_IN)} & ~32'h1)) else $error("bad far target");
	rel12_a: assert property (go && OP_IN == 4'h3
		|=> pc == (($past(pc) + 32'h2 + $past(off12)) & ~32'h1)) else $error("bad rel12");
	cond8_a: assert property (go && OP_IN == 4'h6
		|=> pc == (($past(pc) + $past(INSN_BYTES_IN) + $past(off8)) & ~32'h1)) else $error("bad cond8");
	seq_next_a: assert property (go && OP_IN == 4'h0
		|=> pc == (($past(pc) + $past(INSN_BYTES_IN)) & ~32'h1)) else $error("bad next pc");
	ret_pop_a: assert property (go && (OP_IN == 4'h7 || OP_IN == 4'h8)
		|=> pc == ($past(STACK_DATA_IN) & ~32'h1)) else $error("bad return pc");
	irq_bad_a: assert property (go && OP_IN == 4'h9 && IRQ_NUM_IN == 4'h0 |=> OP_ERROR_OUT)
		else $error("no irq error");
	cover property (go && OP_IN == 4'h9);
	cover property (go && (OP_IN == 4'h7 || OP_IN == 4'h8));
	cover property (go && OP_IN == 4'h2);
	cover property (WDOG_RESET_IN);
endmodule // pc_regfile_checker

bind pc_regfile pc_regfile_checker u_chk (.*);

// *** testbench/pc_regfile_tb.sv ***
`timescale 1ns/1ps
module pc_regfile_tb;
	logic CORE_CLK_IN = '0, RESET_IN = 1'b1, PSEL_IN = '0, PENABLE_IN = '0, PWRITE_IN = '0;
	logic WDOG_RESET_IN = '0, OP_VALID_IN = '0, MOVE_TWO_WORD_IN = '0, REG_WR_IN = '0;
	logic REG_WR_BYTE_IN = '0, er;
	logic [11:0] PADDR_IN = '0, OFFSET_IN = '0;
	logic [31:0] PWDATA_IN = '0, STACK_DATA_IN = '0, pc, rd, q;
	logic [3:0] OP_IN = '0, IRQ_NUM_IN = '0, BASE_SEL_IN = '0, SRC_SEL_IN = '0;
	logic [3:0] MOVE_BASE_SEL_IN = '0, REG_WR_SEL_IN = '0;
	logic [23:0] ABS_TARGET_IN = '0;
	logic [2:0] INSN_BYTES_IN = '0;
	logic [15:0] REG_WR_DATA_IN = '0;
	wire [31:0] PRDATA_OUT, FETCH_ADDR_OUT;
	wire [15:0] MOVE_BASE_OUT, PUSH_LOW_OUT, PUSH_HIGH_OUT, PUSH_STATUS_OUT;
	wire PREADY_OUT, PSLVERR_OUT, PUSH_VALID_OUT, OP_ERROR_OUT;
	int err_count = 0, comparisons = 0;
	pc_regfile u_dut (.*);
	always #2 CORE_CLK_IN = ~CORE_CLK_IN;
	task stop_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Outputs read right at the edge still hold the value settled in the last cycle
	task tick;
		@(posedge CORE_CLK_IN);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		tick;
		PSEL_IN <= 1'b1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		tick;
		PENABLE_IN <= 1'b1;
		n = 0;
		do begin
			tick;
			n++;
		end while (PREADY_OUT !== 1'b1 && n < 20);
		if (PREADY_OUT !== 1'b1) begin
			err_count++;
			stop_test;
		end
		rd = PRDATA_OUT;
		er = PSLVERR_OUT;
		PSEL_IN <= 1'b0;
		PENABLE_IN <= 1'b0;
	endtask
	task core_wr(input logic b, input logic [3:0] s, input logic [15:0] d);
		tick;
		REG_WR_IN <= 1'b1;
		REG_WR_BYTE_IN <= b;
		REG_WR_SEL_IN <= s;
		REG_WR_DATA_IN <= d;
		tick;
		REG_WR_IN <= 1'b0;
	endtask
	task op(input logic [3:0] c, input logic [31:0] exp);
		tick;
		OP_IN <= c;
		OP_VALID_IN <= 1'b1;
		tick;
		OP_VALID_IN <= 1'b0;
		tick;
		pc = exp;
		chk("pc", pc, FETCH_ADDR_OUT);
	endtask
	task s_regs;
		apb(1'b1, 12'h04C, 32'h0000_ABCD);
		apb(1'b0, 12'h04C, '0);
		chk("r3", 32'h0000_ABCD, rd);
		core_wr(1'b1, 4'h3, 16'h1234);
		apb(1'b0, 12'h04C, '0);
		chk("r3 byte", 32'h0000_0034, rd);
		core_wr(1'b0, 4'hE, 16'h00A5);
		apb(1'b0, 12'h010, '0);
		chk("status", 32'h0000_00A5, rd);
		apb(1'b0, 12'h0F0, '0);
		chk("slverr", 32'h1, {31'h0, er});
	endtask
	task s_move;
		core_wr(1'b0, 4'h8, 16'h1357);
		core_wr(1'b0, 4'hD, 16'h2468);
		MOVE_BASE_SEL_IN <= 4'hD;
		tick;
		tick;
		chk("move1", 32'h1357, {16'h0, MOVE_BASE_OUT});
		MOVE_TWO_WORD_IN <= 1'b1;
		tick;
		tick;
		chk("move2", 32'h2468, {16'h0, MOVE_BASE_OUT});
	endtask
	task s_branch;
		ABS_TARGET_IN <= 24'h12_3456;
		op(4'h1, 32'h0012_3456);
		OFFSET_IN <= 12'h800;
		op(4'h3, pc + 32'h2 - 32'h800);
		OFFSET_IN <= 12'h7FE;
		op(4'h3, pc + 32'h2 + 32'h7FE);
		INSN_BYTES_IN <= 3'h4;
		OFFSET_IN <= 12'hF80;
		op(4'h6, pc + 32'h4 - 32'h80);
		op(4'h5, pc + 32'h4 - 32'h80);
		INSN_BYTES_IN <= 3'h2;
		op(4'h0, pc + 32'h2);
		core_wr(1'b0, 4'h5, 16'hFFF0);
		SRC_SEL_IN <= 4'h5;
		op(4'h4, pc + 32'h2 - 32'h10);
		core_wr(1'b0, 4'h8, 16'h0001);
		core_wr(1'b0, 4'h9, 16'h00AB);
		BASE_SEL_IN <= 4'h8;
		op(4'h2, 32'h0001_FFF0);
		BASE_SEL_IN <= 4'h9;
		op(4'h2, 32'h00AB_FFF0);
		BASE_SEL_IN <= 4'h3;
		op(4'h2, 32'h0001_FFF0);
		chk("pair err", 32'h1, {31'h0, OP_ERROR_OUT});
		STACK_DATA_IN <= 32'h00AB_CDE1;
		op(4'h7, 32'h00AB_CDE0);
		STACK_DATA_IN <= 32'h0001_2344;
		op(4'h8, 32'h0001_2344);
	endtask
	task s_irq;
		// Even stack pointer, as software must keep it
		core_wr(1'b0, 4'hF, 16'h0010);
		for (int i = 1; i < 16; i++) begin
			IRQ_NUM_IN <= i[3:0];
			q = pc;
			op(4'h9, 32'h0000_8000 + 4 * i);
			chk("push", q, {PUSH_HIGH_OUT, PUSH_LOW_OUT});
			chk("push st", 32'h0000_00A5, {16'h0, PUSH_STATUS_OUT});
			chk("push vld", 32'h1, {31'h0, PUSH_VALID_OUT});
		end
		apb(1'b0, 12'h00C, '0);
		chk("sp", 32'h0000_006A, rd);
		IRQ_NUM_IN <= 4'h0;
		op(4'h9, pc);
		chk("irq err", 32'h1, {31'h0, OP_ERROR_OUT});
		op(4'hA, 32'h0000_8080);
		WDOG_RESET_IN <= 1'b1;
		tick;
		WDOG_RESET_IN <= 1'b0;
		tick;
		chk("wdog", 32'h0000_8000, FETCH_ADDR_OUT);
	endtask
	initial begin
		repeat (6) tick;
		RESET_IN <= 1'b0;
		pc = 32'h0000_8000;
		tick;
		chk("reset pc", pc, FETCH_ADDR_OUT);
		apb(1'b0, 12'h008, '0);
		chk("apb pc", pc, rd);
		s_regs;
		s_move;
		s_branch;
		s_irq;
		stop_test;
	end
endmodule // pc_regfile_tb
